// File: verilog/exc_unit.sv
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
module exc_unit (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Pins, active low
  input  wire logic                  nmi_pin_n,
  input  wire logic [3:0]            ext_request_pins,
  input  wire logic [5:0]            wakeup_request_pins,
  // Peripheral events
  input  wire logic                  timer_a_event,
  input  wire logic                  direct_xfer_event,
  input  wire logic                  brk_request,
  // CPU sequencer
  input  wire logic                  insn_done,
  input  wire logic [15:0]           next_pc,
  input  wire logic [15:0]           sp,
  input  wire logic [7:0]            condition_code_reg,
  input  wire logic                  rte_done,
  input  wire logic [7:0]            rte_ccr,
  input  wire logic [15:0]           vec_data,
  output exc_pkg::cpu_bus_t          cpu_bus,
  output logic                       cpu_hold,
  output logic                       i_mask
);

  ////////////////////////////////////////////////////////////////////////////
  localparam int NPIN = 11;
  logic [7:0]             edge1_ff;
  logic [5:0]             edge2_ff;
  logic [3:0]             pmode1_ff;
  logic [5:0]             pmode5_ff;
  logic [3:0]             irq_flag_ff;
  logic                   tma_flag_ff;
  logic                   dt_flag_ff;
  logic [7:0]             enable1_ff;
  logic [5:0]             wk_flag_ff;
  logic                   nmi_pend_ff;
  logic                   i_mask_ff;
  logic                   first_blk_ff;
  logic [7:0]             last_vec_ff;
  exc_pkg::exc_state_t    state_ff;
  exc_pkg::exc_state_t    nxt_state;
  logic [2:0]             cnt_ff;
  logic [3:0]             sel_ff;
  exc_pkg::cpu_bus_t      bus_ff;
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  logic [NPIN-1:0] pins;
  logic [NPIN-1:0] s1_ff;
  logic [NPIN-1:0] s2_ff;
  logic [NPIN-1:0] s3_ff;
  logic [NPIN-1:0] lvl_ff;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;
  logic [NPIN-1:0] rise_sel;
  logic [NPIN-1:0] hit;
  assign pins     = {wakeup_request_pins, ext_request_pins, nmi_pin_n};
  assign rise_sel = {edge2_ff, edge1_ff[3:0], edge1_ff[exc_pkg::NMI_EDGE_BIT]};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff  <= '1;
      s2_ff  <= '1;
      s3_ff  <= '1;
      lvl_ff <= '1;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < NPIN; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          lvl_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  // Level moves only once two samples agree, so glitches are dropped
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      rise[i] = (s2_ff[i] == s3_ff[i]) && s3_ff[i] && !lvl_ff[i];
      fall[i] = (s2_ff[i] == s3_ff[i]) && !s3_ff[i] && lvl_ff[i];
    end
  end

  assign hit = (rise & rise_sel) | (fall & ~rise_sel);
  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic        aw_hold_ff;
  logic [7:0]  aw_addr_ff;
  logic        w_hold_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        wr_go;
  logic        wr_ok;
  logic [7:0]  wb;
  assign s_axi_awready = !aw_hold_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_hold_ff && w_hold_ff && w_strb_ff[0];
  assign wb    = w_data_ff[7:0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff   <= 1'b0;
      aw_addr_ff   <= 8'h00;
      w_hold_ff    <= 1'b0;
      w_data_ff    <= 32'h0000_0000;
      w_strb_ff    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= exc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (aw_hold_ff && w_hold_ff) begin
        aw_hold_ff   <= 1'b0;
        w_hold_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? exc_pkg::RESP_OKAY : exc_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    case (aw_addr_ff)
      exc_pkg::OFS_EDGE1, exc_pkg::OFS_EDGE2, exc_pkg::OFS_PMODE1,
      exc_pkg::OFS_PMODE5, exc_pkg::OFS_REQFLAG1, exc_pkg::OFS_ENABLE1,
      exc_pkg::OFS_WKFLAG, exc_pkg::OFS_STATUS: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  logic [7:0] rd_byte;
  logic       rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      exc_pkg::OFS_EDGE1:    rd_byte = edge1_ff;
      exc_pkg::OFS_EDGE2:    rd_byte = {2'b11, edge2_ff};
      exc_pkg::OFS_PMODE1:   rd_byte = {4'h0, pmode1_ff};
      exc_pkg::OFS_PMODE5:   rd_byte = {2'b00, pmode5_ff};
      exc_pkg::OFS_REQFLAG1: rd_byte = {dt_flag_ff, tma_flag_ff, 2'b00, irq_flag_ff};
      exc_pkg::OFS_ENABLE1:  rd_byte = enable1_ff;
      exc_pkg::OFS_WKFLAG:   rd_byte = exc_pkg::WKFLAG_RO | {2'b00, wk_flag_ff};
      exc_pkg::OFS_STATUS:   rd_byte = {nmi_pend_ff, state_ff, 2'b00, first_blk_ff, i_mask_ff};
      default: begin
        rd_byte = exc_pkg::ZERO8;
        rd_ok   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= exc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= (s_axi_araddr == exc_pkg::OFS_STATUS) ?
                      {16'h0000, last_vec_ff, rd_byte} : {24'h000000, rd_byte};
      s_axi_rresp  <= rd_ok ? exc_pkg::RESP_OKAY : exc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge1_ff   <= exc_pkg::EDGE1_RST;
      edge2_ff   <= exc_pkg::EDGE2_RST[5:0];
      pmode1_ff  <= 4'h0;
      pmode5_ff  <= 6'h00;
      enable1_ff <= exc_pkg::ZERO8;
    end else if (wr_go) begin
      case (aw_addr_ff)
        exc_pkg::OFS_EDGE1:   edge1_ff   <= {wb[7], 3'b111, wb[3:0]};
        exc_pkg::OFS_EDGE2:   edge2_ff   <= wb[5:0];
        exc_pkg::OFS_PMODE1:  pmode1_ff  <= wb[3:0];
        exc_pkg::OFS_PMODE5:  pmode5_ff  <= wb[5:0];
        exc_pkg::OFS_ENABLE1: enable1_ff <= {wb[7:5], 1'b0, wb[3:0]};
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request flags: a new edge beats a same-cycle write of 0
  logic       wr_rf1;
  logic       wr_wk;
  logic [3:0] irq_set;
  logic [5:0] wk_set;
  assign wr_rf1  = wr_go && (aw_addr_ff == exc_pkg::OFS_REQFLAG1);
  assign wr_wk   = wr_go && (aw_addr_ff == exc_pkg::OFS_WKFLAG);
  assign irq_set = hit[4:1] & pmode1_ff;
  assign wk_set  = hit[10:5] & pmode5_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_flag_ff <= 4'h0;
      tma_flag_ff <= 1'b0;
      dt_flag_ff  <= 1'b0;
      wk_flag_ff  <= 6'h00;
    end else begin
      irq_flag_ff <= irq_set | (irq_flag_ff & (wr_rf1 ? wb[3:0] : 4'hf));
      tma_flag_ff <= timer_a_event |
                     (tma_flag_ff & (!wr_rf1 || wb[exc_pkg::TMA_BIT]));
      dt_flag_ff  <= direct_xfer_event |
                     (dt_flag_ff & (!wr_rf1 || wb[exc_pkg::DT_BIT]));
      wk_flag_ff  <= wk_set | (wk_flag_ff & (wr_wk ? wb[5:0] : 6'h3f));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration
  logic [exc_pkg::NSRC-1:0] req;
  logic [exc_pkg::NSRC-1:0] nomask;
  logic [3:0]               sel;
  logic                     any_req;
  logic                     accept;
  assign req = {tma_flag_ff & enable1_ff[exc_pkg::TMA_BIT],
                (|wk_flag_ff) & enable1_ff[exc_pkg::WKEN_BIT],
                irq_flag_ff & enable1_ff[3:0],
                dt_flag_ff & enable1_ff[exc_pkg::DT_BIT],
                brk_request,
                nmi_pend_ff};
  assign nomask = 9'h003;
  // Lowest index wins; others simply stay pending
  always_comb begin
    sel     = 4'h0;
    any_req = 1'b0;
    for (int i = exc_pkg::NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        sel     = 4'(i);
        any_req = 1'b1;
      end
    end
  end

  assign accept = (state_ff == exc_pkg::ST_RUN) && insn_done && !first_blk_ff &&
                  any_req && (nomask[sel] || !i_mask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Exception sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      exc_pkg::ST_RESET_VEC:
        if (cnt_ff == 3'(exc_pkg::VECTOR_STATES - 1)) nxt_state = exc_pkg::ST_RUN;
      exc_pkg::ST_RUN:
        if (accept) nxt_state = exc_pkg::ST_STACK;
      exc_pkg::ST_STACK:
        if (cnt_ff == 3'(exc_pkg::STACK_STATES - 1)) nxt_state = exc_pkg::ST_VECTOR;
      exc_pkg::ST_VECTOR:
        if (cnt_ff == 3'(exc_pkg::VECTOR_STATES - 1)) nxt_state = exc_pkg::ST_IFETCH;
      exc_pkg::ST_IFETCH:
        if (cnt_ff == 3'(exc_pkg::IFETCH_STATES - 1)) nxt_state = exc_pkg::ST_INTERNAL;
      exc_pkg::ST_INTERNAL:
        if (cnt_ff == 3'(exc_pkg::INTERNAL_STATES - 1)) nxt_state = exc_pkg::ST_RUN;
      default: nxt_state = exc_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= exc_pkg::ST_RESET_VEC;
      cnt_ff   <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= (nxt_state != state_ff) ? 3'h0 : cnt_ff + 3'h1;
    end
  end

  logic [7:0]  vnum;
  logic [15:0] pc_keep_ff;
  logic [7:0]  ccr_keep_ff;
  assign vnum = exc_pkg::VEC_NUMS[sel_ff * 8 +: 8];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_ff      <= 4'h0;
      last_vec_ff <= 8'h00;
      pc_keep_ff  <= 16'h0000;
      ccr_keep_ff <= 8'h00;
    end else if (accept) begin
      sel_ff      <= sel;
      last_vec_ff <= exc_pkg::VEC_NUMS[sel * 8 +: 8];
      pc_keep_ff  <= next_pc;
      ccr_keep_ff <= condition_code_reg;
    end
  end

  // Stack frame: PC at sp-2, CONDITION_CODE_REG at sp-4, word aligned
  logic [15:0] sp_pc;
  logic [15:0] sp_ccr;
  assign sp_pc  = (sp - 16'h0002) & 16'hfffe;
  assign sp_ccr = (sp - 16'h0004) & 16'hfffe;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_ff <= '0;
    end else begin
      bus_ff.stack_wr <= 1'b0;
      bus_ff.pc_load  <= 1'b0;
      bus_ff.vec_rd   <= 1'b0;
      case (state_ff)
        exc_pkg::ST_RESET_VEC: begin
          bus_ff.vec_rd   <= 1'b1;
          bus_ff.vec_addr <= exc_pkg::RESET_VEC_ADDR;
          if (nxt_state == exc_pkg::ST_RUN) begin
            bus_ff.pc_load  <= 1'b1;
            bus_ff.pc_value <= vec_data;
          end
        end
        exc_pkg::ST_STACK: begin
          if (cnt_ff == 3'h0) begin
            bus_ff.stack_wr   <= 1'b1;
            bus_ff.stack_addr <= sp_pc;
            bus_ff.stack_data <= pc_keep_ff;
          end else if (cnt_ff == 3'h2) begin
            bus_ff.stack_wr   <= 1'b1;
            bus_ff.stack_addr <= sp_ccr;
            bus_ff.stack_data <= {ccr_keep_ff, ccr_keep_ff};
          end
        end
        exc_pkg::ST_VECTOR: begin
          bus_ff.vec_rd   <= 1'b1;
          bus_ff.vec_addr <= {7'h00, vnum, 1'b0};
          if (nxt_state == exc_pkg::ST_IFETCH) begin
            bus_ff.pc_load  <= 1'b1;
            bus_ff.pc_value <= vec_data & 16'hfffe;
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mask bit, non-maskable pending, post-reset block
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      i_mask_ff <= 1'b1;
    end else if (state_ff == exc_pkg::ST_STACK &&
                 nxt_state == exc_pkg::ST_VECTOR) begin
      i_mask_ff <= 1'b1;
    end else if (rte_done && state_ff == exc_pkg::ST_RUN) begin
      i_mask_ff <= rte_ccr[exc_pkg::CCR_I_BIT];
    end
  end

  // Edges during the block are held, not dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_pend_ff <= 1'b0;
    end else begin
      nmi_pend_ff <= hit[0] | (nmi_pend_ff & !(accept && sel == 4'h0));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_blk_ff <= 1'b1;
    end else if (state_ff == exc_pkg::ST_RUN && insn_done) begin
      first_blk_ff <= 1'b0;
    end
  end

  assign cpu_bus  = bus_ff;
  assign cpu_hold = (state_ff != exc_pkg::ST_RUN);
  assign i_mask   = i_mask_ff;
endmodule : exc_unit

// File: verilog/exc_pkg.sv
package exc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_EDGE1    = 8'h00;
  localparam logic [7:0] OFS_EDGE2    = 8'h04;
  localparam logic [7:0] OFS_PMODE1   = 8'h08;
  localparam logic [7:0] OFS_PMODE5   = 8'h0c;
  localparam logic [7:0] OFS_REQFLAG1 = 8'h10;
  localparam logic [7:0] OFS_ENABLE1  = 8'h14;
  localparam logic [7:0] OFS_WKFLAG   = 8'h18;
  localparam logic [7:0] OFS_STATUS   = 8'h1c;

  // Field positions
  localparam int NMI_EDGE_BIT = 7;
  localparam int DT_BIT       = 7;
  localparam int TMA_BIT      = 6;
  localparam int WKEN_BIT     = 5;
  localparam int CCR_I_BIT    = 7;

  // Reset values and read-only bits
  localparam logic [7:0] EDGE1_RST  = 8'h70;
  localparam logic [7:0] EDGE2_RST  = 8'hc0;
  localparam logic [7:0] WKFLAG_RO  = 8'hc0;
  localparam logic [7:0] ZERO8      = 8'h00;

  // Timing in states, one state per clock
  localparam int RESET_MIN_CYCLES = 10;
  localparam int STACK_STATES     = 4;
  localparam int VECTOR_STATES    = 2;
  localparam int IFETCH_STATES    = 4;
  localparam int INTERNAL_STATES  = 4;

  // Sources by priority: nmi, break, dt, irq0..3, wakeup, timer a
  localparam int NSRC = 9;
  localparam logic [15:0] RESET_VEC_ADDR = 16'h0000;
  localparam logic [8*NSRC-1:0] VEC_NUMS = {8'h0c, 8'h0b, 8'h0a, 8'h09, 8'h08,
                                            8'h07, 8'h06, 8'h05, 8'h04};

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ST_RESET_VEC = 3'b000,
    ST_RUN       = 3'b001,
    ST_STACK     = 3'b010,
    ST_VECTOR    = 3'b011,
    ST_IFETCH    = 3'b100,
    ST_INTERNAL  = 3'b101
  } exc_state_t;

  typedef struct packed {
    logic        stack_wr;
    logic [15:0] stack_addr;
    logic [15:0] stack_data;
    logic        vec_rd;
    logic [15:0] vec_addr;
    logic        pc_load;
    logic [15:0] pc_value;
  } cpu_bus_t;

endpackage : exc_pkg

// File: verif/exc_unit_chk.sv
`timescale 1ns/10ps
module exc_unit_chk (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // CPU link
  input  wire logic              insn_done,
  input  wire logic              rte_done,
  input  wire logic [7:0]        rte_ccr,
  input  wire logic [15:0]       vec_data,
  input  wire exc_pkg::cpu_bus_t cpu_bus,
  input  wire logic              cpu_hold,
  input  wire logic              i_mask
);
  logic rte_i;

  assign rte_i = rte_ccr[7];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////
  // Reset itself is the cause here, so it must not disable the check
  property p_reset_clear;
    disable iff (1'b0) !aresetn |=> cpu_hold && i_mask && !cpu_bus.stack_wr && !cpu_bus.pc_load;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left outputs active");
  property p_reset_vec;
    $rose(aresetn) |-> ##[1:3] (cpu_bus.vec_rd && cpu_bus.vec_addr == exc_pkg::RESET_VEC_ADDR)
      ##[1:2] (cpu_bus.pc_load && i_mask);
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset vector load missing");
  property p_take_edge;
    $rose(cpu_hold) |-> $past(insn_done) && !$past(cpu_hold);
  endproperty
  a_take_edge: assert property (p_take_edge) else $error("taken mid instruction");
  property p_stack;
    $rose(cpu_hold) |-> ##1 cpu_bus.stack_wr ##1 !cpu_bus.stack_wr ##1 cpu_bus.stack_wr;
  endproperty
  a_stack: assert property (p_stack) else $error("stack writes out of place");
  property p_mask_set;
    $rose(cpu_hold) |-> ##4 i_mask;
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask not set after stacking");
  property p_vector;
    $rose(cpu_hold) |-> ##5 (cpu_bus.vec_rd && !cpu_bus.vec_addr[0])
      ##1 (cpu_bus.pc_load && cpu_bus.pc_value == ($past(vec_data) & 16'hfffe));
  endproperty
  a_vector: assert property (p_vector) else $error("handler address not loaded");
  property p_hold_len;
    $rose(cpu_hold) |-> ##13 cpu_hold ##1 !cpu_hold;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("response length wrong");
  property p_even_stack;
    cpu_bus.stack_wr |-> !cpu_bus.stack_addr[0];
  endproperty
  a_even_stack: assert property (p_even_stack) else $error("odd stack address");
  property p_rte;
    rte_done && !cpu_hold |=> i_mask == $past(rte_i);
  endproperty
  a_rte: assert property (p_rte) else $error("mask not restored on return");
endmodule : exc_unit_chk

bind exc_unit exc_unit_chk chk (.aclk, .aresetn, .insn_done, .rte_done, .rte_ccr, .vec_data,
                                 .cpu_bus, .cpu_hold, .i_mask);

// File: verif/exc_cpu_model.sv
`timescale 1ns/10ps
module exc_cpu_model (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Bench control
  input  wire logic              stall,
  input  wire logic              rte_req,
  input  wire logic [7:0]        rte_val,
  // Device side
  input  wire exc_pkg::cpu_bus_t cpu_bus,
  input  wire logic              cpu_hold,
  input  wire logic              i_mask,
  output logic                   insn_done,
  output logic [15:0]            next_pc,
  output logic [15:0]            sp,
  output logic [7:0]             condition_code_reg,
  output logic                   rte_done,
  output logic [7:0]             rte_ccr,
  output logic [15:0]            vec_data
);
  logic [4:0]  wait_ff;
  logic [15:0] noise_ff;

  // Odd pointer on purpose: the device must drop bit 0
  assign sp                 = 16'h0f01;
  assign condition_code_reg = {i_mask, 7'h15};
  assign rte_done           = rte_req && !cpu_hold;
  assign rte_ccr            = rte_val;
  // Released read bus shows a moving pattern, never the last word
  assign vec_data  = cpu_bus.vec_rd ? {cpu_bus.vec_addr[7:0], 8'h31} : noise_ff;
  assign insn_done = aresetn && !stall && !cpu_hold && wait_ff == 5'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_ff  <= 5'h00;
      next_pc  <= 16'h0100;
      noise_ff <= 16'h5a5a;
    end else begin
      noise_ff <= ~noise_ff + 16'h1357;
      if (insn_done) begin
        wait_ff <= (noise_ff[4:0] > 5'h16) ? 5'h16 : noise_ff[4:0];
        next_pc <= next_pc + 16'h0002;
      end else if (wait_ff != 5'h00 && !cpu_hold) begin
        wait_ff <= wait_ff - 5'h01;
      end
    end
  end
endmodule : exc_cpu_model

// File: verif/exc_unit_tb.sv
`timescale 1ns/10ps
module exc_unit_tb;
  logic              aclk, aresetn, stall, rte_req, second;
  logic [7:0]        s_axi_awaddr, s_axi_araddr, condition_code_reg, rte_ccr, rte_val;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb, ext_request_pins;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic              nmi_pin_n, timer_a_event, direct_xfer_event, brk_request;
  logic              insn_done, rte_done, cpu_hold, i_mask;
  logic [5:0]        wakeup_request_pins, pat;
  logic [15:0]       next_pc, sp, vec_data, exp_sd;
  exc_pkg::cpu_bus_t cpu_bus;
  logic [33:0]       rd_q[$], pc_q[$], b_q[$];
  int                err_count, check_count, seed;
  int                srcs[3] = '{2, 7, 8};
  logic [7:0]        clr_a[3] = '{exc_pkg::OFS_REQFLAG1, exc_pkg::OFS_WKFLAG, exc_pkg::OFS_REQFLAG1};
  logic [7:0]        clr_d[3] = '{8'h7f, 8'h00, 8'h00};
  logic [7:0]        def_a[5] = '{exc_pkg::OFS_EDGE1, exc_pkg::OFS_EDGE2, exc_pkg::OFS_WKFLAG,
                                  exc_pkg::OFS_REQFLAG1, 8'h20};
  logic [33:0]       def_e[5] = '{34'h70, 34'hc0, 34'hc0, 34'h0, 34'h200000000};

  exc_unit      dut (.*);
  exc_cpu_model cpu (.*);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    if (pc_q.size() != 0) err_count++;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  function automatic logic [33:0] hv(input int k);
    logic [7:0] vn;
    vn = exc_pkg::VEC_NUMS[8*k +: 8];
    return {18'h0, vn[6:0], 1'b0, 8'h30};
  endfunction : hv

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    b_q.push_back(34'h0);
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rd_q.push_back(e);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
  endtask : rd

  task automatic do_rte(input logic [7:0] v);
    rte_val <= v;
    rte_req <= 1'b1;
    @(posedge aclk);
    while (!rte_done) @(posedge aclk);
    rte_req <= 1'b0;
  endtask : do_rte

  task automatic wait_pc;
    repeat (500) if (pc_q.size() != 0) @(posedge aclk);
  endtask : wait_pc

  task automatic do_reset;
    // Pin idles high through reset so no stale edge follows release
    nmi_pin_n <= 1'b1;
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    pc_q.push_back(34'h0031);
    aresetn <= 1'b1;
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: each read, write and pc result is matched against the oldest note; stack writes against fixed addresses and the CPU's values
  always @(posedge aclk) begin
    if (!aresetn) second = 1'b0;
    if (s_axi_rvalid && s_axi_rready) check("rdata", {s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
    if (s_axi_bvalid) check("bresp", {32'h0, s_axi_bresp}, b_q.pop_front());
    if (cpu_bus.pc_load) check("pc", {18'h0, cpu_bus.pc_value}, pc_q.size() ? pc_q.pop_front() : '1);
    if (cpu_bus.stack_wr) begin
      check("stack_addr", {18'h0, cpu_bus.stack_addr}, second ? 34'h0efc : 34'h0efe);
      exp_sd = second ? {condition_code_reg, condition_code_reg} : next_pc - 16'h0002;
      check("stack_data", {18'h0, cpu_bus.stack_data}, {18'h0, exp_sd});
      second = ~second;
    end
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    wrap_up();
  end

  initial begin
    seed                <= 32'h1d63;
    stall               <= 1'b1;
    rte_req             <= 1'b0;
    rte_val             <= 8'h80;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
    // Ready to take every answer, so back-to-back calls never re-drive it
    {s_axi_bready, s_axi_rready} <= 2'b11;
    s_axi_awaddr        <= 8'h00;
    s_axi_araddr        <= 8'h00;
    s_axi_wdata         <= 32'h0;
    s_axi_wstrb         <= 4'hf;
    ext_request_pins    <= 4'hf;
    wakeup_request_pins <= 6'h3f;
    {timer_a_event, direct_xfer_event, brk_request} <= 3'h0;
    do_reset();
    // Nothing may be taken before the first instruction
    nmi_pin_n <= 1'b0;
    repeat (8) @(posedge aclk);
    rd(exc_pkg::OFS_STATUS, 34'h93);
    foreach (def_a[i]) rd(def_a[i], def_e[i]);
    pc_q.push_back(hv(0));
    stall <= 1'b0;
    wait_pc();
    $display("reset and first instruction done");
    wr(exc_pkg::OFS_PMODE1, 8'h07);
    wr(exc_pkg::OFS_EDGE1, 8'h75);
    ext_request_pins <= 4'h0;
    repeat (6) @(posedge aclk);
    rd(exc_pkg::OFS_REQFLAG1, 34'h02);
    ext_request_pins <= 4'hf;
    repeat (6) @(posedge aclk);
    rd(exc_pkg::OFS_REQFLAG1, 34'h07);
    wr(exc_pkg::OFS_REQFLAG1, 8'h00);
    rd(exc_pkg::OFS_REQFLAG1, 34'h00);
    wr(exc_pkg::OFS_ENABLE1, 8'h04);
    ext_request_pins <= 4'hb;
    repeat (6) @(posedge aclk);
    ext_request_pins <= 4'hf;
    pc_q.push_back(hv(5));
    do_rte(8'h00);
    wait_pc();
    wr(exc_pkg::OFS_REQFLAG1, 8'h00);
    pc_q.push_back(hv(1));
    brk_request <= 1'b1;
    wait_pc();
    brk_request <= 1'b0;
    $display("pin requests done");
    wr(exc_pkg::OFS_EDGE1, 8'hf5);
    repeat (4) @(posedge aclk);
    pc_q.push_back(hv(0));
    nmi_pin_n <= 1'b1;
    wait_pc();
    nmi_pin_n <= 1'b0;
    repeat (30) @(posedge aclk);
    $display("nonmaskable edge done");
    wr(exc_pkg::OFS_PMODE5, 8'h3f);
    wr(exc_pkg::OFS_ENABLE1, 8'he0);
    pat = 6'($random(seed)) | 6'h01;
    wakeup_request_pins <= ~pat;
    timer_a_event       <= 1'b1;
    direct_xfer_event   <= 1'b1;
    @(posedge aclk);
    timer_a_event       <= 1'b0;
    direct_xfer_event   <= 1'b0;
    repeat (6) @(posedge aclk);
    rd(exc_pkg::OFS_WKFLAG, {26'h0, 2'b11, pat});
    rd(exc_pkg::OFS_REQFLAG1, 34'hc0);
    // Highest pending goes first; each handler clears its own flag
    for (int k = 0; k < 3; k++) begin
      pc_q.push_back(hv(srcs[k]));
      do_rte(8'h00);
      wait_pc();
      wr(clr_a[k], clr_d[k]);
    end
    do_rte(8'h00);
    repeat (40) @(posedge aclk);
    $display("priority done");
    do_reset();
    repeat (8) @(posedge aclk);
    rd(exc_pkg::OFS_ENABLE1, 34'h00);
    wait_pc();
    $display("second reset done");
    wrap_up();
  end
endmodule : exc_unit_tb
